// ### common/cohwl_pkg.sv
`default_nettype none
package cohwl_pkg;
  localparam logic [2:0] OP_IDX_INV    = 3'h0;
  localparam logic [2:0] OP_IDX_LDTAG  = 3'h1;
  localparam logic [2:0] OP_IDX_STTAG  = 3'h2;
  localparam logic [2:0] OP_HIT_INV    = 3'h4;
  localparam logic [2:0] OP_HIT_WBINV  = 3'h5;
  localparam logic [2:0] OP_HIT_WB     = 3'h6;
  localparam logic [2:0] OP_FETCH_LOCK = 3'h7;
  localparam logic [1:0] CSEL_I = 2'h0;
  localparam logic [1:0] CSEL_D = 2'h1;
  localparam logic [1:0] CSEL_T = 2'h2;
  localparam logic [1:0] CSEL_S = 2'h3;
  localparam int INSTR_W  = 32;
  localparam int OPF_MSB  = 20;
  localparam int OPF_LSB  = 18;
  localparam int CSEL_MSB = 17;
  localparam int CSEL_LSB = 16;
  localparam logic [1:0] UNMAPPED_USER_SEG_MODE     = 2'h0;
  localparam logic [1:0] MAPPED_USER_SEG_MODE       = 2'h1;
  localparam logic [1:0] USER_MAPPED_KERNEL_SEG_MODE = 2'h2;
  localparam logic [1:0] OTHER_SEG_MODE             = 2'h3;
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_CPU  = 2'h1;
  localparam logic [1:0] EXC_ADDR = 2'h2;
  localparam logic [1:0] EXC_TLB  = 2'h3;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_W    = 2;
  localparam int CTRL_WT   = 0;
  localparam int CTRL_GLOB = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_NOP     = 1;
  localparam int STAT_EXC_LSB = 2;
endpackage
`default_nettype wire

// ### hw/cohwl_core.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cohwl_core #(
  parameter int AW    = 32,
  parameter int OFF_W = 5,
  parameter int IDX_W = 6,
  parameter int WAY_W = 2,
  parameter int TAG_W = AW - OFF_W - IDX_W
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // Pipeline request and answer
  input  wire logic                         req_valid_i,
  input  wire logic [cohwl_pkg::INSTR_W-1:0] instr_i,
  input  wire logic [AW-1:0]                vaddr_i,
  input  wire logic                         cp0_en_i,
  input  wire logic [1:0]                   seg_mode_i,
  input  wire logic                         coherent_i,
  input  wire logic [TAG_W-1:0]             stag_tag_i,
  input  wire logic                         stag_valid_i,
  input  wire logic                         stag_dirty_i,
  input  wire logic                         stag_lock_i,
  output logic                              req_ready_o,
  output logic                              done_o,
  output logic                              nop_o,
  output logic [1:0]                        exc_o,
  // Translation buffer
  output logic                              tlb_req_o,
  output logic [AW-1:0]                     tlb_vaddr_o,
  output logic                              tlb_user_map_o,
  input  wire logic                         tlb_ack_i,
  input  wire logic                         tlb_miss_i,
  input  wire logic                         tlb_uncached_i,
  input  wire logic [AW-1:0]                tlb_paddr_i,
  // Next memory level
  output logic                              mem_req_o,
  output logic                              mem_we_o,
  output logic [AW-1:0]                     mem_addr_o,
  output logic [1:0]                        mem_lvl_o,
  input  wire logic                         mem_ack_i,
  // Coherence
  output logic                              coh_bcast_o,
  input  wire logic                         ext_inv_i,
  input  wire logic [AW-1:0]                ext_inv_addr_i,
  // Register port
  input  wire logic [cohwl_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [cohwl_pkg::REG_DW-1:0] reg_wdata_i,
  input  wire logic                         reg_we_i,
  input  wire logic                         reg_re_i,
  output logic [cohwl_pkg::REG_DW-1:0]      reg_rdata_o
);
  localparam int WAYS  = 2 ** WAY_W;
  localparam int LW    = IDX_W + WAY_W;
  localparam int LINES = 2 ** LW;

  typedef enum logic [2:0] {S_IDLE, S_XLAT, S_LOOK, S_WB, S_FILL, S_DONE} cohwl_st_e;

  cohwl_st_e            state_r;
  cohwl_st_e            state_nxt;
  logic [TAG_W-1:0]     tag_r [LINES];
  logic [LINES-1:0]     val_r;
  logic [LINES-1:0]     dty_r;
  logic [LINES-1:0]     lck_r;
  logic [2:0]           op_r;
  logic [1:0]           csel_r;
  logic [AW-1:0]        addr_r;
  logic                 unc_r;
  logic                 coh_r;
  logic [TAG_W+2:0]     stag_r;
  logic [LW-1:0]        line_r;
  logic                 fill_after_r;
  logic                 inv_after_r;
  logic [WAY_W-1:0]     rr_r;
  logic [1:0]           exc_r;
  logic                 nop_r;
  logic                 ready_r;
  logic                 done_r;
  logic                 tlb_req_r;
  logic [AW-1:0]        tlb_vaddr_r;
  logic                 tlb_user_map_r;
  logic                 mem_req_r;
  logic                 mem_we_r;
  logic [AW-1:0]        mem_addr_r;
  logic [1:0]           mem_lvl_r;
  logic                 coh_bcast_r;
  logic [cohwl_pkg::CTRL_W-1:0] ctrl_r;
  logic [cohwl_pkg::REG_DW-1:0] rdata_r;
  logic [cohwl_pkg::REG_DW-1:0] status_w;
  logic                 arr_we;
  logic [LW-1:0]        arr_line;
  logic [TAG_W-1:0]     arr_tag;
  logic                 arr_v;
  logic                 arr_d;
  logic                 arr_l;

  function automatic logic [WAY_W-1:0] first_one(input logic [WAYS-1:0] v);
    first_one = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_one = WAY_W'(i);
      end
    end
  endfunction

  function automatic logic [WAYS-1:0] ways_hit(input logic [IDX_W-1:0] ix,
                                               input logic [TAG_W-1:0] tg);
    ways_hit = '0;
    for (int w = 0; w < WAYS; w++) begin
      ways_hit[w] = val_r[{ix, WAY_W'(w)}] && (tag_r[{ix, WAY_W'(w)}] == tg);
    end
  endfunction

  function automatic logic is_idx(input logic [2:0] op);
    is_idx = (op == cohwl_pkg::OP_IDX_INV) || (op == cohwl_pkg::OP_IDX_LDTAG) ||
             (op == cohwl_pkg::OP_IDX_STTAG);
  endfunction

  // Tag readout stays with the neighbouring block, so it counts as unimplemented here.
  function automatic logic op_impl(input logic [2:0] op, input logic [1:0] cs);
    case (op)
      cohwl_pkg::OP_IDX_INV, cohwl_pkg::OP_IDX_STTAG,
      cohwl_pkg::OP_HIT_INV, cohwl_pkg::OP_HIT_WBINV: op_impl = 1'b1;
      cohwl_pkg::OP_HIT_WB:     op_impl = (cs != cohwl_pkg::CSEL_I);
      cohwl_pkg::OP_FETCH_LOCK: op_impl = (cs == cohwl_pkg::CSEL_I) || (cs == cohwl_pkg::CSEL_D);
      default:                  op_impl = 1'b0;
    endcase
  endfunction

  wire [2:0]       req_op_w  = instr_i[cohwl_pkg::OPF_MSB:cohwl_pkg::OPF_LSB];
  wire [1:0]       req_cs_w  = instr_i[cohwl_pkg::CSEL_MSB:cohwl_pkg::CSEL_LSB];
  wire             seg_ok_w  = (seg_mode_i != cohwl_pkg::OTHER_SEG_MODE);
  wire             chk_ok_w  = cp0_en_i && seg_ok_w;
  wire             take_w    = (state_r == S_IDLE) && req_valid_i;
  wire [IDX_W-1:0] idx_w     = addr_r[OFF_W +: IDX_W];
  wire [TAG_W-1:0] tag_w     = addr_r[AW-1 -: TAG_W];
  wire [WAY_W-1:0] iway_w    = addr_r[OFF_W+IDX_W +: WAY_W];
  logic [WAYS-1:0] hit_v;
  logic [WAYS-1:0] ext_hv;
  // A process rather than a wire, so that writes to the tag arrays also wake the lookup.
  always_comb begin
    hit_v  = ways_hit(idx_w, tag_w);
    ext_hv = ways_hit(ext_inv_addr_i[OFF_W +: IDX_W], ext_inv_addr_i[AW-1 -: TAG_W]);
  end
  wire             hit_w     = |hit_v;
  wire [WAY_W-1:0] hway_w    = first_one(hit_v);
  wire             wt_w      = ctrl_r[cohwl_pkg::CTRL_WT];
  wire             is_fl_w   = (op_r == cohwl_pkg::OP_FETCH_LOCK);
  wire             is_hwb_w  = (op_r == cohwl_pkg::OP_HIT_WB);
  wire             impl_w    = op_impl(op_r, csel_r);
  wire             idx_op_w  = is_idx(op_r);

  logic [WAYS-1:0] set_lck;
  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++) begin : g_lck
      assign set_lck[gw] = lck_r[{idx_w, WAY_W'(gw)}];
    end
  endgenerate

  // Locked ways are skipped; with every way locked the round-robin pointer decides.
  wire             unl_any_w = |(~set_lck);
  wire [WAY_W-1:0] vic_way_w = unl_any_w ? first_one(~set_lck) : rr_r;
  wire             proceed_w = impl_w && !(unc_r && !idx_op_w) &&
                               !(is_hwb_w && wt_w);
  // One line is selected: the indexed way, the victim on a fetch-and-lock miss, otherwise the first hit way.
  wire [LW-1:0]    line_w    = idx_op_w ? {idx_w, iway_w} :
                               (is_fl_w && !hit_w) ? {idx_w, vic_way_w} :
                               {idx_w, hway_w};
  wire             ldty_w    = dty_r[line_w] && val_r[line_w];
  wire             wb_w      = proceed_w && ldty_w && !wt_w &&
                               ((op_r == cohwl_pkg::OP_IDX_INV) ||
                                ((op_r == cohwl_pkg::OP_HIT_WBINV || is_hwb_w) && hit_w) ||
                                (is_fl_w && !hit_w));
  wire [LW-1:0]    wb_line_w = (state_r == S_LOOK) ? line_w : line_r;
  wire [AW-1:0]    wb_addr_w = {tag_r[wb_line_w], wb_line_w[LW-1:WAY_W], {OFF_W{1'b0}}};
  wire [AW-1:0]    fl_addr_w = {tag_w, idx_w, {OFF_W{1'b0}}};
  wire             mem_nxt_w = (state_nxt == S_WB) || (state_nxt == S_FILL);

  always_comb begin
    state_nxt = state_r;
    arr_we    = 1'b0;
    arr_line  = wb_line_w;
    arr_tag   = tag_r[wb_line_w];
    arr_v     = val_r[wb_line_w];
    arr_d     = dty_r[wb_line_w];
    arr_l     = lck_r[wb_line_w];
    case (state_r)
      S_IDLE: begin
        if (req_valid_i) begin
          state_nxt = !chk_ok_w ? S_DONE :
                      (is_idx(req_op_w) || seg_mode_i == cohwl_pkg::UNMAPPED_USER_SEG_MODE) ?
                      S_LOOK : S_XLAT;
        end
      end
      S_XLAT: begin
        if (tlb_ack_i) begin
          state_nxt = tlb_miss_i ? S_DONE : S_LOOK;
        end
      end
      S_LOOK: begin
        if (!proceed_w) begin
          state_nxt = S_DONE;
        end else if (wb_w) begin
          state_nxt = S_WB;
        end else begin
          state_nxt = (is_fl_w && !hit_w) ? S_FILL : S_DONE;
          case (op_r)
            cohwl_pkg::OP_IDX_INV, cohwl_pkg::OP_HIT_INV, cohwl_pkg::OP_HIT_WBINV: begin
              arr_we = idx_op_w || hit_w;
              arr_v  = 1'b0;
              arr_d  = 1'b0;
              arr_l  = 1'b0;
            end
            cohwl_pkg::OP_IDX_STTAG: begin
              arr_we = 1'b1;
              {arr_tag, arr_v, arr_d, arr_l} = stag_r;
            end
            cohwl_pkg::OP_FETCH_LOCK: begin
              arr_we = hit_w;
              arr_l  = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      S_WB: begin
        if (mem_ack_i) begin
          arr_we    = 1'b1;
          arr_d     = 1'b0;
          arr_v     = arr_v && !inv_after_r && !fill_after_r;
          arr_l     = arr_l && !inv_after_r && !fill_after_r;
          state_nxt = fill_after_r ? S_FILL : S_DONE;
        end
      end
      S_FILL: begin
        if (mem_ack_i) begin
          arr_we    = 1'b1;
          arr_tag   = tag_w;
          arr_v     = 1'b1;
          arr_d     = 1'b0;
          arr_l     = 1'b1;
          state_nxt = S_DONE;
        end
      end
      S_DONE:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (arr_we) begin
      tag_r[arr_line] <= arr_tag;
    end
  end

  // The external invalidate is applied last so that it wins, locked or not.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      val_r <= '0;
      dty_r <= '0;
      lck_r <= '0;
    end else begin
      if (arr_we) begin
        val_r[arr_line] <= arr_v;
        dty_r[arr_line] <= arr_d;
        lck_r[arr_line] <= arr_l;
      end
      for (int w = 0; w < WAYS; w++) begin
        if (ext_inv_i && ext_hv[w]) begin
          val_r[{ext_inv_addr_i[OFF_W +: IDX_W], WAY_W'(w)}] <= 1'b0;
          dty_r[{ext_inv_addr_i[OFF_W +: IDX_W], WAY_W'(w)}] <= 1'b0;
          lck_r[{ext_inv_addr_i[OFF_W +: IDX_W], WAY_W'(w)}] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      op_r    <= '0;
      csel_r  <= '0;
      addr_r  <= '0;
      unc_r   <= 1'b0;
      coh_r   <= 1'b0;
      stag_r  <= '0;
      exc_r   <= cohwl_pkg::EXC_NONE;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == S_IDLE);
      if (take_w) begin
        op_r   <= req_op_w;
        csel_r <= req_cs_w;
        addr_r <= vaddr_i;
        unc_r  <= 1'b0;
        coh_r  <= coherent_i;
        stag_r <= {stag_tag_i, stag_valid_i, stag_dirty_i, stag_lock_i};
        exc_r  <= !cp0_en_i ? cohwl_pkg::EXC_CPU :
                  !seg_ok_w ? cohwl_pkg::EXC_ADDR : cohwl_pkg::EXC_NONE;
      end
      if (state_r == S_XLAT && tlb_ack_i) begin
        if (tlb_miss_i) begin
          exc_r <= cohwl_pkg::EXC_TLB;
        end else begin
          addr_r <= tlb_paddr_i;
          unc_r  <= tlb_uncached_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      line_r       <= '0;
      fill_after_r <= 1'b0;
      inv_after_r  <= 1'b0;
      rr_r         <= '0;
      nop_r        <= 1'b0;
    end else if (take_w) begin
      nop_r <= !chk_ok_w;
    end else if (state_r == S_XLAT && tlb_ack_i && tlb_miss_i) begin
      nop_r <= 1'b1;
    end else if (state_r == S_LOOK) begin
      line_r       <= line_w;
      fill_after_r <= is_fl_w;
      inv_after_r  <= !is_hwb_w;
      nop_r        <= !proceed_w;
      if (proceed_w && is_fl_w && !hit_w) begin
        rr_r <= rr_r + WAY_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_r         <= 1'b0;
      tlb_req_r      <= 1'b0;
      tlb_vaddr_r    <= '0;
      tlb_user_map_r <= 1'b0;
      mem_req_r      <= 1'b0;
      mem_we_r       <= 1'b0;
      mem_addr_r     <= '0;
      mem_lvl_r      <= '0;
      coh_bcast_r    <= 1'b0;
    end else begin
      done_r         <= (state_r == S_DONE);
      tlb_req_r      <= take_w && (state_nxt == S_XLAT);
      tlb_vaddr_r    <= take_w ? vaddr_i : tlb_vaddr_r;
      tlb_user_map_r <= take_w ? (seg_mode_i == cohwl_pkg::USER_MAPPED_KERNEL_SEG_MODE) :
                        tlb_user_map_r;
      mem_req_r      <= mem_nxt_w;
      mem_we_r       <= (state_nxt == S_WB);
      mem_addr_r     <= (state_nxt == S_WB) ? wb_addr_w : fl_addr_w;
      mem_lvl_r      <= csel_r;
      coh_bcast_r    <= (state_r == S_LOOK) && proceed_w && is_hwb_w && coh_r &&
                        ctrl_r[cohwl_pkg::CTRL_GLOB];
    end
  end

  always_comb begin
    status_w = '0;
    status_w[cohwl_pkg::STAT_BUSY] = !ready_r;
    status_w[cohwl_pkg::STAT_NOP]  = nop_r;
    status_w[cohwl_pkg::STAT_EXC_LSB +: 2] = exc_r;
  end

  wire [cohwl_pkg::REG_DW-1:0] rd_mux_w =
    (reg_addr_i == cohwl_pkg::REG_CTRL)   ? {{(cohwl_pkg::REG_DW-cohwl_pkg::CTRL_W){1'b0}}, ctrl_r} :
    (reg_addr_i == cohwl_pkg::REG_STATUS) ? status_w : '0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r  <= cohwl_pkg::CTRL_RST;
      rdata_r <= '0;
    end else begin
      if (reg_we_i && reg_addr_i == cohwl_pkg::REG_CTRL) begin
        ctrl_r <= reg_wdata_i[cohwl_pkg::CTRL_W-1:0];
      end
      rdata_r <= reg_re_i ? rd_mux_w : '0;
    end
  end

  assign req_ready_o    = ready_r;
  assign done_o         = done_r;
  assign nop_o          = nop_r;
  assign exc_o          = exc_r;
  assign tlb_req_o      = tlb_req_r;
  assign tlb_vaddr_o    = tlb_vaddr_r;
  assign tlb_user_map_o = tlb_user_map_r;
  assign mem_req_o      = mem_req_r;
  assign mem_we_o       = mem_we_r;
  assign mem_addr_o     = mem_addr_r;
  assign mem_lvl_o      = mem_lvl_r;
  assign coh_bcast_o    = coh_bcast_r;
  assign reg_rdata_o    = rdata_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_done_nop;
    (state_r == S_DONE) ##1 (done_o && nop_o);
  endsequence
  sequence s_done_exc(logic [1:0] e);
    (state_r == S_DONE) ##1 (done_o && exc_o == e);
  endsequence

  tlb_req_pulse_a: assert property (tlb_req_o |=> !tlb_req_o && state_r == S_XLAT)
    else $error("translation request not a single pulse");
  user_map_sel_a: assert property (tlb_req_o |->
    tlb_user_map_o == ($past(seg_mode_i) == cohwl_pkg::USER_MAPPED_KERNEL_SEG_MODE))
    else $error("wrong mapping selected");
  priv_check_a: assert property (take_w && !cp0_en_i |=> s_done_exc(cohwl_pkg::EXC_CPU))
    else $error("disabled access not refused");
  unimpl_nop_a: assert property ((state_r == S_LOOK) && !proceed_w |=> s_done_nop)
    else $error("skipped operation did not end as nop");
  wt_hitwb_nop_a: assert property ((state_r == S_LOOK) && impl_w && is_hwb_w && wt_w
    |=> !mem_req_o ##0 s_done_nop)
    else $error("write-through hit writeback made traffic");
  hitwb_write_a: assert property ((state_r == S_LOOK) && wb_w && is_hwb_w
    |=> mem_req_o && mem_we_o)
    else $error("dirty hit line not written back");
  hitwb_clean_a: assert property ((state_r == S_WB) && mem_ack_i && is_hwb_w && !ext_inv_i
    |=> val_r[line_r] && !dty_r[line_r])
    else $error("hit writeback left line dirty or invalid");
  fill_locks_a: assert property ((state_r == S_FILL) && mem_ack_i && !ext_inv_i
    |=> val_r[line_r] && lck_r[line_r] && !dty_r[line_r])
    else $error("filled line not valid and locked");
  lock_hit_a: assert property ((state_r == S_LOOK) && proceed_w && is_fl_w && hit_w
    |=> (state_r == S_DONE) && !mem_req_o)
    else $error("locked hit caused a refill");
  lock_clear_a: assert property ((state_r == S_LOOK) && proceed_w && hit_w
    && (op_r == cohwl_pkg::OP_HIT_INV) && !ext_inv_i |=> !lck_r[line_r])
    else $error("hit invalidate left the line locked");
  victim_free_a: assert property ((state_r == S_LOOK) && is_fl_w && !hit_w && unl_any_w
    |-> !set_lck[vic_way_w])
    else $error("locked way chosen as victim");
endmodule
`default_nettype wire

// ### testbench/cache_op_hit_writeback_lock_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cache_op_hit_writeback_lock_tb;
  localparam logic [2:0] HWB = cohwl_pkg::OP_HIT_WB;
  localparam logic [2:0] FL  = cohwl_pkg::OP_FETCH_LOCK;
  localparam logic [1:0] D   = cohwl_pkg::CSEL_D;
  logic        clk_i, rst_n_i, req_valid_i, cp0_en_i, coherent_i, unc, re_d;
  logic        stag_valid_i, stag_dirty_i, stag_lock_i, reg_we_i, reg_re_i, ext_inv_i;
  logic        req_ready_o, done_o, nop_o, tlb_req_o, tlb_user_map_o, tlb_ack_i;
  logic        tlb_uncached_i, mem_req_o, mem_we_o, mem_ack_i, coh_bcast_o;
  logic [1:0]  seg_mode_i, exc_o, mem_lvl_o;
  logic [3:0]  reg_addr_i;
  logic [20:0] stag_tag_i;
  logic [31:0] instr_i, vaddr_i, reg_wdata_i, ext_inv_addr_i, tlb_vaddr_o, tlb_paddr_i;
  logic [31:0] mem_addr_o, reg_rdata_o, a_line, b_line;
  logic [2:0]  exp_done_q[$];
  logic [34:0] exp_mem_q[$];
  logic [31:0] exp_reg_q[$];
  int          fail_count, samples_checked, seed, bcast_n;

  cohwl_core i_dut (
    .clk_i, .rst_n_i, .req_valid_i, .instr_i, .vaddr_i, .cp0_en_i, .seg_mode_i, .coherent_i,
    .stag_tag_i, .stag_valid_i, .stag_dirty_i, .stag_lock_i, .req_ready_o, .done_o, .nop_o,
    .exc_o, .tlb_req_o, .tlb_vaddr_o, .tlb_user_map_o, .tlb_ack_i, .tlb_miss_i(1'b0),
    .tlb_uncached_i, .tlb_paddr_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_lvl_o,
    .mem_ack_i, .coh_bcast_o, .ext_inv_i, .ext_inv_addr_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o);
  cohwl_far_model i_far (.clk_i, .rst_n_i, .tlb_req_i(tlb_req_o), .tlb_vaddr_i(tlb_vaddr_o),
    .uncached_i(unc), .tlb_ack_o(tlb_ack_i), .tlb_uncached_o(tlb_uncached_i),
    .tlb_paddr_o(tlb_paddr_i), .mem_req_i(mem_req_o), .mem_ack_o(mem_ack_i));

  always #2 clk_i = ~clk_i;

  task automatic test_done();
    $display("Checked %0d results, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rep(input logic [34:0] got, input logic [34:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An empty queue yields all ones, so an unexpected result always mismatches.
  task automatic chk_done(input logic [2:0] got);
    rep({32'h0, got}, exp_done_q.size() > 0 ? {32'h0, exp_done_q.pop_front()} : '1);
  endtask
  task automatic chk_mem(input logic [34:0] got);
    rep(got, exp_mem_q.size() > 0 ? exp_mem_q.pop_front() : '1);
  endtask
  task automatic chk_reg(input logic [31:0] got);
    rep({3'h0, got}, exp_reg_q.size() > 0 ? {3'h0, exp_reg_q.pop_front()} : '1);
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (req_ready_o !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 500) begin
        fail_count++;
        test_done();
      end
    end
  endtask
  task automatic rg(input logic we, input logic [3:0] ad, input logic [31:0] d);
    idle();
    @(posedge clk_i);
    reg_we_i <= we;
    reg_re_i <= ~we;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    if (!we) exp_reg_q.push_back(d);
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic req(input logic [2:0] op, input logic [1:0] cs, input logic [1:0] sm,
                     input logic cp, input logic [31:0] a, input logic [2:0] e);
    idle();
    @(posedge clk_i);
    exp_done_q.push_back(e);
    instr_i <= {11'h0, op, cs, 16'h0};
    seg_mode_i <= sm;
    cp0_en_i <= cp;
    vaddr_i <= a;
    req_valid_i <= 1'b1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (done_o === 1'b1) chk_done({nop_o, exc_o});
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) chk_mem({mem_lvl_o, mem_we_o, mem_addr_o});
    if (tlb_req_o === 1'b1)
      rep({2'h0, tlb_user_map_o, tlb_vaddr_o}, {2'h0, seg_mode_i == 2'h2, vaddr_i});
    if (coh_bcast_o === 1'b1) bcast_n++;
    if (re_d === 1'b1) chk_reg(reg_rdata_o);
    re_d <= reg_re_i;
  end

  initial begin
    clk_i = 1'b0; rst_n_i = 1'b0; req_valid_i = 1'b0; cp0_en_i = 1'b0; coherent_i = 1'b0;
    unc = 1'b0; stag_valid_i = 1'b1; stag_dirty_i = 1'b1; stag_lock_i = 1'b0; re_d = 1'b0;
    reg_we_i = 1'b0; reg_re_i = 1'b0; ext_inv_i = 1'b0; seg_mode_i = 2'h0; reg_addr_i = 4'h0;
    instr_i = 32'h0; vaddr_i = 32'h0; reg_wdata_i = 32'h0; ext_inv_addr_i = 32'h0;
    fail_count = 0; samples_checked = 0; seed = 43297; bcast_n = 0;
    // Index addresses sit in the unmapped cached segment; one way is ever locked.
    // No request targets executing code; each writeback is awaited before the next.
    a_line = 32'h8000_1a40;
    b_line = 32'h8000_5a40;
    stag_tag_i = a_line[31:11];
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    rg(1'b0, cohwl_pkg::REG_CTRL, 32'h0);
    rg(1'b1, 4'h8, 32'hffff_ffff);
    rg(1'b0, 4'h8, 32'h0);
    for (int m = 0; m < 4; m++) begin
      req(cohwl_pkg::OP_IDX_STTAG, D, 2'h0, 1'b1, a_line, 3'h0);
      if (m < 3) exp_mem_q.push_back({D, 1'b1, a_line});
      req(HWB, D, 2'(m), 1'b1, a_line | (32'($random(seed)) & 32'h1f),
          m < 3 ? 3'h0 : {1'b1, cohwl_pkg::EXC_ADDR});
    end
    req(HWB, D, 2'h2, 1'b0, a_line, {1'b1, cohwl_pkg::EXC_CPU});
    rg(1'b0, cohwl_pkg::REG_STATUS, 32'h6);
    req(HWB, cohwl_pkg::CSEL_I, 2'h2, 1'b1, a_line, 3'h4);
    req(FL, cohwl_pkg::CSEL_T, 2'h2, 1'b1, b_line, 3'h4);
    req(cohwl_pkg::OP_IDX_LDTAG, D, 2'h0, 1'b1, a_line, 3'h4);
    idle();
    @(posedge clk_i);
    unc <= 1'b1;
    req(HWB, D, 2'h2, 1'b1, a_line, 3'h4);
    idle();
    @(posedge clk_i);
    unc <= 1'b0;
    rg(1'b1, cohwl_pkg::REG_CTRL, 32'h1);
    rg(1'b0, cohwl_pkg::REG_CTRL, 32'h1);
    req(HWB, D, 2'h2, 1'b1, a_line, 3'h4);
    rg(1'b0, cohwl_pkg::REG_STATUS, 32'h2);
    rg(1'b1, cohwl_pkg::REG_CTRL, 32'h2);
    @(posedge clk_i);
    coherent_i <= 1'b1;
    exp_mem_q.push_back({cohwl_pkg::CSEL_S, 1'b1, a_line});
    req(cohwl_pkg::OP_HIT_WB, cohwl_pkg::CSEL_S, 2'h1, 1'b1, a_line, 3'h0);
    exp_mem_q.push_back({D, 1'b0, b_line});
    req(FL, D, 2'h2, 1'b1, b_line, 3'h0);
    req(FL, D, 2'h2, 1'b1, b_line | 32'h4, 3'h0);
    idle();
    @(posedge clk_i);
    ext_inv_i <= 1'b1;
    ext_inv_addr_i <= b_line;
    @(posedge clk_i);
    ext_inv_i <= 1'b0;
    exp_mem_q.push_back({D, 1'b0, b_line});
    req(FL, D, 2'h2, 1'b1, b_line, 3'h0);
    req(cohwl_pkg::OP_HIT_INV, D, 2'h2, 1'b1, b_line, 3'h0);
    exp_mem_q.push_back({D, 1'b0, b_line});
    req(FL, D, 2'h2, 1'b1, b_line, 3'h0);
    idle();
    repeat (4) @(posedge clk_i);
    rep(35'(bcast_n), 35'h1);
    rep(35'(exp_done_q.size() + exp_mem_q.size() + exp_reg_q.size()), 35'h0);
    test_done();
  end
endmodule
`default_nettype wire

// ### testbench/cohwl_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cohwl_far_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Translation side
  input  wire logic        tlb_req_i,
  input  wire logic [31:0] tlb_vaddr_i,
  input  wire logic        uncached_i,
  output logic             tlb_ack_o,
  output logic             tlb_uncached_o,
  output logic [31:0]      tlb_paddr_o,
  // Memory side
  input  wire logic        mem_req_i,
  output logic             mem_ack_o
);
  logic [1:0] tw_r;
  logic [1:0] mw_r;
  logic       tp_r;
  logic       slow_r;
  // Outside an answer the lines carry the inverse, so stale values never pass.
  assign tlb_paddr_o    = tlb_ack_o ? tlb_vaddr_i : ~tlb_vaddr_i;
  assign tlb_uncached_o = tlb_ack_o ? uncached_i : ~uncached_i;
  // Translation answers alternate between prompt and slow; the memory wait follows the translation toggle.
  always_ff @(posedge clk_i) begin
    tlb_ack_o <= 1'b0;
    mem_ack_o <= 1'b0;
    if (!rst_n_i) begin
      tp_r   <= 1'b0;
      tw_r   <= 2'h0;
      mw_r   <= 2'h0;
      slow_r <= 1'b0;
    end else begin
      if (tlb_req_i) begin
        tp_r   <= 1'b1;
        tw_r   <= slow_r ? 2'h3 : 2'h0;
        slow_r <= ~slow_r;
      end else if (tp_r && tw_r != 2'h0) begin
        tw_r <= tw_r - 2'h1;
      end else if (tp_r) begin
        tp_r      <= 1'b0;
        tlb_ack_o <= 1'b1;
      end
      if (mem_req_i && !mem_ack_o) begin
        if (mw_r == 2'h0) begin
          mem_ack_o <= 1'b1;
          mw_r      <= {slow_r, 1'b0};
        end else begin
          mw_r <= mw_r - 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire
